//--- src/ulab_map.vh
`ifndef ULAB_MAP_VH
`define ULAB_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ULAB_ADR_CFG      32'h40064000
`define ULAB_ADR_CTL      32'h40064004
`define ULAB_ADR_STAT     32'h40064008
`define ULAB_ADR_MASK     32'h4006400c
`define ULAB_ADR_TXDATA   32'h40064010
`define ULAB_ADR_RXDATA   32'h40064014
`define ULAB_ADR_MATCH    32'h40064018

// ****************************************************************
// Configuration fields
// ****************************************************************
`define ULAB_CFG_OUTPUT_ENABLE_TURNAROUND     18
`define ULAB_CFG_AUTO     19
`define ULAB_CFG_OUTPUT_ENABLE_SELECT    20
`define ULAB_CFG_OUTPUT_ENABLE_POLARITY    21
`define ULAB_CFG_RECEIVE_LINE_INVERT    22
`define ULAB_CFG_TRANSMIT_LINE_INVERT    23

// ****************************************************************
// Control fields
// ****************************************************************
`define ULAB_CTL_BRK      1
`define ULAB_CTL_ADET     2
`define ULAB_CTL_TRANSMIT_DISABLE    6

// ****************************************************************
// Status fields, the mask shares the low three
// ****************************************************************
`define ULAB_ST_RX        0
`define ULAB_ST_TRANSMIT_DISABLE     1
`define ULAB_ST_TXDONE    2
`define ULAB_ST_TXBUSY    8
`define ULAB_ST_RXFULL    9
`define ULAB_ST_TXFULL    10

// ****************************************************************
// Reset values
// ****************************************************************
`define ULAB_RST_CFG      6'h00
`define ULAB_RST_CTL      3'h0
`define ULAB_RST_MATCH    8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ULAB_MCLK_HZ      20000000
`define ULAB_BAUD_HZ      115200
`define ULAB_BIT_CYCLES   (`ULAB_MCLK_HZ / `ULAB_BAUD_HZ)
`define ULAB_HALF_CYCLES  (`ULAB_BIT_CYCLES / 2)
`define ULAB_CHAR_BITS    10

`endif

//--- src/ulab_rx.v
`timescale 1ns/1ps
`include "ulab_map.vh"

// ****************************************************************
// Receiver: start, eight data bits LSB first, one stop bit
// ****************************************************************
module ulab_rx (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_rxd,
  output reg        o_valid,
  output reg  [7:0] o_data
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA  = 2'h2;
  localparam [1:0] ST_STOP  = 2'h3;
  localparam integer BIT_LAST_I = `ULAB_BIT_CYCLES - 1;
  localparam integer HALF_I     = `ULAB_HALF_CYCLES;
  localparam [7:0]   BIT_LAST   = BIT_LAST_I[7:0];
  localparam [7:0]   HALF       = HALF_I[7:0];

  reg  [1:0] state_ff;
  reg  [7:0] cnt_ff;
  reg  [2:0] bit_ff;
  reg        rxd_ff;

  // One sample stage keeps the edge search on a clean register.
  always @(posedge i_clk) begin
    if (i_rst) begin
      rxd_ff <= 1'b1;
    end else begin
      rxd_ff <= i_rxd;
    end
  end

  // Sampling lands mid-bit by waiting half a bit after the edge.
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 8'h00;
      bit_ff   <= 3'h0;
      o_valid  <= 1'b0;
      o_data   <= 8'h00;
    end else begin
      o_valid <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= 8'h00;
          if (!rxd_ff) begin
            state_ff <= ST_START;
          end
        end
        ST_START: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == HALF) begin
            cnt_ff   <= 8'h00;
            bit_ff   <= 3'h0;
            // A glitch shorter than half a bit is not a start.
            state_ff <= rxd_ff ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == BIT_LAST) begin
            cnt_ff <= 8'h00;
            o_data <= {rxd_ff, o_data[7:1]};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              state_ff <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == BIT_LAST) begin
            // A framing error drops the character silently.
            o_valid  <= rxd_ff;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ulab_rx

//--- src/ulab_usart_ctrl.v
// What this block does
// - With address detect on and hardware matching off, addresses are left to software.
// - With address detect and hardware matching on, an address character is compared with the match register.
// - The output-enable select bit chooses between flow control and transceiver enable on RTS.
// - The enable is driven active low when its polarity bit is 0 and active high when 1.
// - With receive invert clear, the incoming line is used as it is.
// - With receive invert set, the incoming line is inverted before use.
// - With transmit invert clear, the transmit line is driven as it is.
// - With transmit invert set, the transmit line is inverted.
// - Setting break enable forces a break at once and holds it until the bit is cleared.
// - With address detect clear, every received character is passed on.
// - With address detect set and hardware matching off, characters with a clear top bit are dropped and others received.
// - Transmit disable stops the transmitter only after the character in flight ends.
// - With turnaround on, the enable stays on one character time after the stop bit, or longer.
`timescale 1ns/1ps
`include "ulab_map.vh"

module ulab_usart_ctrl (
  input  wire        I_MCLK,
  input  wire        I_SRST,
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [31:0] I_WB_ADR,
  input  wire [3:0]  I_WB_SEL,
  input  wire [31:0] I_WB_DAT,
  output reg  [31:0] O_WB_DAT,
  output reg         O_WB_ACK,
  input  wire        I_RXD,
  output reg         O_TXD,
  output reg         O_RTS,
  output reg         O_IRQ
);

  // The integer forms are cut to the counter widths on purpose.
  localparam integer BIT_LAST_I  = `ULAB_BIT_CYCLES - 1;
  localparam integer CHAR_BITS_I = `ULAB_CHAR_BITS;
  localparam [7:0]   BIT_LAST    = BIT_LAST_I[7:0];
  localparam [3:0]   CHAR_BITS   = CHAR_BITS_I[3:0];

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        req    = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire        wr     = req & I_WB_WE;
  wire [31:0] lane;
  wire        wr_cfg = wr & (I_WB_ADR == `ULAB_ADR_CFG);
  wire        wr_ctl = wr & (I_WB_ADR == `ULAB_ADR_CTL);
  wire        wr_st  = wr & (I_WB_ADR == `ULAB_ADR_STAT);
  wire        wr_msk = wr & (I_WB_ADR == `ULAB_ADR_MASK);
  wire        wr_tx  = wr & (I_WB_ADR == `ULAB_ADR_TXDATA) & I_WB_SEL[0];
  wire        wr_mat = wr & (I_WB_ADR == `ULAB_ADR_MATCH);
  wire        rd_rx  = req & ~I_WB_WE & (I_WB_ADR == `ULAB_ADR_RXDATA);

  // Byte enables widen into a bit mask, one lane per select line.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign lane[8*g+7:8*g] = {8{I_WB_SEL[g]}};
    end
  endgenerate

  wire [31:0] wdat = I_WB_DAT & lane;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [5:0] cfg_ff;    // Bits 23 to 18 of the configuration word.
  reg  [2:0] ctl_ff;    // Break, address detect, transmit disable.
  reg  [2:0] stat_ff;   // Sticky events.
  reg  [2:0] mask_ff;
  reg  [7:0] match_ff;
  reg  [7:0] rxdat_ff;
  reg        rxfull_ff;
  reg  [7:0] txhold_ff;
  reg        txfull_ff;
  reg        addressed_ff;

  wire output_enable_turnaround   = cfg_ff[`ULAB_CFG_OUTPUT_ENABLE_TURNAROUND  - 18];
  wire autoad = cfg_ff[`ULAB_CFG_AUTO  - 18];
  wire output_enable_select  = cfg_ff[`ULAB_CFG_OUTPUT_ENABLE_SELECT - 18];
  wire output_enable_polarity  = cfg_ff[`ULAB_CFG_OUTPUT_ENABLE_POLARITY - 18];
  wire receive_line_invert  = cfg_ff[`ULAB_CFG_RECEIVE_LINE_INVERT - 18];
  wire transmit_line_invert  = cfg_ff[`ULAB_CFG_TRANSMIT_LINE_INVERT - 18];
  wire brk    = ctl_ff[0];
  wire adet   = ctl_ff[1];
  wire transmit_disable  = ctl_ff[2];

  // Only the written lanes of a field change.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      cfg_ff   <= `ULAB_RST_CFG;
      ctl_ff   <= `ULAB_RST_CTL;
      mask_ff  <= 3'h0;
      match_ff <= `ULAB_RST_MATCH;
    end else begin
      if (wr_cfg && I_WB_SEL[2]) begin
        cfg_ff <= wdat[23:18];
      end
      if (wr_ctl && I_WB_SEL[0]) begin
        ctl_ff <= {wdat[`ULAB_CTL_TRANSMIT_DISABLE], wdat[`ULAB_CTL_ADET],
                   wdat[`ULAB_CTL_BRK]};
      end
      if (wr_msk && I_WB_SEL[0]) begin
        mask_ff <= wdat[2:0];
      end
      if (wr_mat && I_WB_SEL[0]) begin
        match_ff <= wdat[7:0];
      end
    end
  end

  // ****************************************************************
  // Receiver and address filter
  // ****************************************************************
  wire       rx_valid;
  wire [7:0] rx_data;

  // The invert sits ahead of the receiver, so its edge search always
  // sees the corrected idle level.
  ulab_rx u_rx (
    .i_clk   (I_MCLK),
    .i_rst   (I_SRST),
    .i_rxd   (I_RXD ^ receive_line_invert),
    .o_valid (rx_valid),
    .o_data  (rx_data)
  );

  reg  accept;
  wire is_addr = rx_data[7];
  wire hit     = (rx_data == match_ff);

  // Decide whether a finished character reaches software.
  always @* begin
    accept = 1'b1;
    if (adet) begin
      if (!autoad) begin
        accept = is_addr;
      end else begin
        accept = is_addr ? hit : addressed_ff;
      end
    end
  end

  // Hardware matching remembers whether the last address was ours, so
  // data after a matching address flows until a foreign one arrives.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      addressed_ff <= 1'b0;
      rxdat_ff     <= 8'h00;
      rxfull_ff    <= 1'b0;
    end else begin
      if (!adet || !autoad) begin
        addressed_ff <= 1'b0;
      end else if (rx_valid && is_addr) begin
        addressed_ff <= hit;
      end
      if (rx_valid && accept) begin
        rxdat_ff <= rx_data;
      end
      // A new character wins over a read in the same cycle.
      if (rx_valid && accept) begin
        rxfull_ff <= 1'b1;
      end else if (rd_rx) begin
        rxfull_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  reg  [7:0] baud_ff;
  reg        tick_ff;
  reg  [9:0] shift_ff;
  reg  [3:0] nbit_ff;
  reg        busy_ff;
  reg  [3:0] ta_ff;
  reg        done;

  // Free-running bit divider; starts align to it, so the first bit of
  // a character is as long as the rest.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      baud_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (baud_ff == BIT_LAST);
      baud_ff <= (baud_ff == BIT_LAST) ? 8'h00 : baud_ff + 8'h01;
    end
  end

  wire start = tick_ff & ~busy_ff & txfull_ff & ~transmit_disable & ~brk;

  always @* begin
    done = tick_ff & busy_ff & (nbit_ff == CHAR_BITS - 4'h1);
  end

  // Disable is checked only at a start, so a character in flight ends.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      shift_ff  <= 10'h3ff;
      nbit_ff   <= 4'h0;
      busy_ff   <= 1'b0;
      txhold_ff <= 8'h00;
      txfull_ff <= 1'b0;
    end else begin
      if (wr_tx && !txfull_ff) begin
        txhold_ff <= wdat[7:0];
        txfull_ff <= 1'b1;
      end
      if (start) begin
        shift_ff  <= {1'b1, txhold_ff, 1'b0};
        nbit_ff   <= 4'h0;
        busy_ff   <= 1'b1;
        txfull_ff <= 1'b0;
      end else if (tick_ff && busy_ff) begin
        shift_ff <= {1'b1, shift_ff[9:1]};
        nbit_ff  <= nbit_ff + 4'h1;
        if (done) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

  // Turnaround counts bit ticks; a new start cancels the tail.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      ta_ff <= 4'h0;
    end else if (start) begin
      ta_ff <= 4'h0;
    end else if (done) begin
      ta_ff <= output_enable_turnaround ? CHAR_BITS : 4'h0;
    end else if (tick_ff && ta_ff != 4'h0) begin
      ta_ff <= ta_ff - 4'h1;
    end
  end

  wire oe_on = busy_ff | start | (ta_ff != 4'h0);

  // ****************************************************************
  // Status and interrupt
  // ****************************************************************
  wire [2:0] ev = {done, transmit_disable & ~busy_ff, rx_valid & accept};

  // An event in the clearing cycle survives: set beats clear.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      stat_ff <= 3'h0;
    end else begin
      stat_ff <= ev | (stat_ff & ~((wr_st && I_WB_SEL[0]) ?
                                   wdat[2:0] : 3'h0));
    end
  end

  // ****************************************************************
  // Pins, bus answer
  // ****************************************************************
  reg [31:0] rdat;

  // Unmapped addresses and reserved bits read as zero.
  always @* begin
    rdat = 32'h00000000;
    case (I_WB_ADR)
      `ULAB_ADR_CFG:    rdat[23:18] = cfg_ff;
      `ULAB_ADR_CTL:    rdat = {25'h0, ctl_ff[2], 3'h0, ctl_ff[1:0], 1'b0};
      `ULAB_ADR_STAT:   rdat = {21'h0, txfull_ff, rxfull_ff, busy_ff,
                                5'h00, stat_ff};
      `ULAB_ADR_MASK:   rdat[2:0] = mask_ff;
      `ULAB_ADR_RXDATA: rdat[7:0] = rxdat_ff;
      `ULAB_ADR_MATCH:  rdat[7:0] = match_ff;
      default:          rdat = 32'h00000000;
    endcase
  end

  // Break drives the space level, which the invert bit then flips.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
      O_TXD    <= 1'b1;
      O_RTS    <= 1'b1;
      O_IRQ    <= 1'b0;
    end else begin
      O_WB_ACK <= req;
      if (req) begin
        O_WB_DAT <= I_WB_WE ? 32'h00000000 : (rdat & lane);
      end
      O_TXD <= (brk ? 1'b0 : shift_ff[0]) ^ transmit_line_invert;
      if (output_enable_select) begin
        O_RTS <= output_enable_polarity ? oe_on : ~oe_on;
      end else begin
        O_RTS <= rxfull_ff;
      end
      O_IRQ <= |(stat_ff & mask_ff);
    end
  end

endmodule // ulab_usart_ctrl

//--- tb/ulab_serial_node.sv
`timescale 1ns/1ps
// ****************************************
// Remote serial node, 8N1 at 173 clocks a bit
// ****************************************
module ulab_serial_node (
  input  wire i_clk,
  input  wire i_txd,
  output reg  o_rxd
);
  localparam int BT = 173;
  logic inv = 1'b0;
  initial o_rxd = 1'b1;
  // Rests the line at the idle level of the current polarity.
  task automatic idle();
    o_rxd <= ~inv;
  endtask
  // One frame; the stop bit leaves the line idle between frames.
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int k = 0; k < 10; k++) begin
      o_rxd <= f[k] ^ inv;
      repeat (BT) @(posedge i_clk);
    end
  endtask
  // Samples each bit at its middle; returns during the stop bit.
  task automatic recv(output logic [7:0] c);
    while ((i_txd ^ inv) !== 1'b0) @(posedge i_clk);
    repeat (BT / 2) @(posedge i_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BT) @(posedge i_clk);
      c[k] = i_txd ^ inv;
    end
    repeat (BT) @(posedge i_clk);
  endtask
endmodule // ulab_serial_node

//--- tb/ulab_usart_ctrl_checker.sv
`timescale 1ns/1ps
`include "ulab_map.vh"
// ****************************************
// Port checker for the line control block
// ****************************************
module ulab_usart_ctrl_checker (
  input wire        I_MCLK,
  input wire        I_SRST,
  input wire        I_WB_CYC,
  input wire        I_WB_STB,
  input wire        I_WB_WE,
  input wire [31:0] I_WB_ADR,
  input wire [3:0]  I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  input wire [31:0] O_WB_DAT,
  input wire        O_WB_ACK,
  input wire        I_RXD,
  input wire        O_TXD,
  input wire        O_RTS,
  input wire        O_IRQ
);
  logic [31:0] cfg_ff, ctl_ff, msk_ff;
  wire         wr_go = I_WB_CYC & I_WB_STB & I_WB_WE & ~O_WB_ACK;
  // Shadow of the fields the pins depend on, updated as writes land.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      cfg_ff <= 0;
      ctl_ff <= 0;
      msk_ff <= 0;
    end else if (wr_go) begin
      if (I_WB_ADR == `ULAB_ADR_CFG) cfg_ff <= I_WB_DAT;
      if (I_WB_ADR == `ULAB_ADR_CTL) ctl_ff <= I_WB_DAT;
      if (I_WB_ADR == `ULAB_ADR_MASK) msk_ff <= I_WB_DAT;
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  ack_next_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("bus request not answered in time");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  wr_data_a: assert property (O_WB_ACK && $past(I_WB_WE) |-> O_WB_DAT == 0)
    else $error("write answered with data");
  unmap_read_a: assert property (O_WB_ACK && !$past(I_WB_WE)
    && $past(I_WB_ADR) == 32'h40064020 |-> O_WB_DAT == 0)
    else $error("unmapped read not zero");
  reset_pins_a: assert property (disable iff (1'b0) I_SRST
    |=> O_TXD && O_RTS && !O_IRQ && !O_WB_ACK) else $error("reset levels");
  break_line_a: assert property (ctl_ff[1] && $past(ctl_ff[1], 2)
    |-> O_TXD == cfg_ff[23]) else $error("break level not held");
  oe_drive_a: assert property (cfg_ff[20] && $stable(cfg_ff)
    && O_TXD == cfg_ff[23] && $past(O_TXD) == cfg_ff[23] && !ctl_ff[1]
    && !$past(ctl_ff[1], 4) |-> O_RTS == cfg_ff[21])
    else $error("enable not active while sending");
  irq_masked_a: assert property (msk_ff[2:0] == 0 && $past(msk_ff[2:0]) == 0
    |-> !O_IRQ) else $error("interrupt with all sources masked");
  brk_seen_c: cover property (ctl_ff[1] && O_TXD == cfg_ff[23]);
  oe_on_c: cover property (cfg_ff[20] && O_RTS == cfg_ff[21]);
  irq_seen_c: cover property (O_IRQ && msk_ff[0]);
endmodule // ulab_usart_ctrl_checker
bind ulab_usart_ctrl ulab_usart_ctrl_checker chk_u (.I_MCLK(I_MCLK),
  .I_SRST(I_SRST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
  .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .I_RXD(I_RXD), .O_TXD(O_TXD), .O_RTS(O_RTS), .O_IRQ(O_IRQ));

//--- tb/ulab_usart_ctrl_tb.sv
`timescale 1ns/1ps
`include "ulab_map.vh"
// ****************************************
// Self-checking bench for the line control block
// ****************************************
module ulab_usart_ctrl_tb;
  logic        mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, rv;
  logic [3:0]  sel = 4'hf;
  logic        ack, txd, rts, irq, rxd;
  logic [7:0]  b, got;
  logic        k;
  logic [16:0] lfsr = 17'd70207;
  int          err_total = 0, checks_done = 0, i, p, n;
  ulab_usart_ctrl dut_u (.I_MCLK(mclk), .I_SRST(srst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_RXD(rxd),
    .O_TXD(txd), .O_RTS(rts), .O_IRQ(irq));
  ulab_serial_node node_u (.i_clk(mclk), .i_txd(txd), .o_rxd(rxd));
  // Free-running 20 MHz clock.
  initial forever #25 mclk = ~mclk;
  // Next pseudo-random byte; the sequence repeats run after run.
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction
  // Whether a character passes the address filter, match value 8'h85;
  // m tells whether the last address character was ours.
  function automatic logic keep(logic ad, logic au, logic m, logic [7:0] c);
    return !ad || (au ? (c[7] ? c == 8'h85 : m) : c[7]);
  endfunction
  // Pin level for an enable state and polarity.
  function automatic logic oe_pin(logic pol, logic en);
    return pol ? en : !en;
  endfunction
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask
  // Classic single cycle; the answer is awaited, never assumed.
  task automatic wb(input logic w, input logic [31:0] a, d);
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1 && ++n < 40);
    if (n >= 40) chk(0, 1);
    rv = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [31:0] a, m, e);
    wb(0, a, 0);
    chk(rv & m, e);
  endtask
  task automatic wr(input logic [31:0] a, d);
    wb(1, a, d);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog at about three times the expected run length.
  initial begin
    wt(90000);
    err_total++;
    complete_run();
  end
  // Main sequence.
  initial begin
    wt(20);
    srst <= 0;
    wt(1);
    rd(`ULAB_ADR_CFG, 32'hffffffff, 0);
    rd(`ULAB_ADR_CTL, 32'hffffffff, 0);
    rd(32'h40064020, 32'hffffffff, 0);
    chk({txd, irq}, 2'b10);
    $display("reset test done");
    for (p = 0; p < 2; p++) begin
      wr(`ULAB_ADR_CFG, {8'h0, p[0], p[0], 22'h0});
      node_u.inv = p[0];
      node_u.idle();
      wt(4);
      chk(txd, !p[0]);
      b = rnd();
      wr(`ULAB_ADR_TXDATA, b);
      node_u.recv(got);
      chk(got, b);
      b = rnd();
      node_u.send(b);
      wt(10);
      chk(rts, 1);
      rd(`ULAB_ADR_RXDATA, 32'hff, b);
    end
    $display("polarity test done");
    wr(`ULAB_ADR_CFG, 0);
    node_u.inv = 0;
    node_u.idle();
    wr(`ULAB_ADR_MATCH, 32'h85);
    for (i = 0; i < 9; i++) begin
      b = (i == 1) ? 8'h35 : (i == 6) ? 8'ha5 : (i == 7) ? 8'h85 : rnd();
      // Data after our own address must flow under hardware matching.
      if (i == 8) b[7] = 1'b0;
      wr(`ULAB_ADR_CFG, {12'h0, i > 5, 19'h0});
      wr(`ULAB_ADR_CTL, {29'h0, i > 0, 2'h0});
      wr(`ULAB_ADR_STAT, 32'h7);
      node_u.send(b);
      wt(10);
      k = keep(i > 0, i > 5, i == 8, b);
      rd(`ULAB_ADR_STAT, 32'h1, k);
      if (k) rd(`ULAB_ADR_RXDATA, 32'hff, b);
    end
    // Raise, mask, unmask, then clear by writing a one.
    for (i = 0; i < 4; i++) begin
      wr(i == 3 ? `ULAB_ADR_STAT : `ULAB_ADR_MASK, i != 1);
      wt(2);
      chk(irq, i == 0 || i == 2);
    end
    $display("address and interrupt test done");
    wr(`ULAB_ADR_CTL, 32'h40);
    rv = 0;
    for (i = 0; i < 50 && rv[1] !== 1'b1; i++) wb(0, `ULAB_ADR_STAT, 0);
    chk(rv[1], 1);
    wr(`ULAB_ADR_CTL, 32'h42);
    wt(2);
    chk(txd, 0);
    wt(300);
    chk(txd, 0);
    wr(`ULAB_ADR_CTL, 0);
    wt(3);
    chk(txd, 1);
    $display("break test done");
    for (p = 0; p < 2; p++) begin
      wr(`ULAB_ADR_CFG, {10'h0, p[0], 3'h5, 18'h0});
      wt(2);
      chk(rts, oe_pin(p[0], 0));
      b = rnd();
      wr(`ULAB_ADR_TXDATA, b);
      // Disable lands while the character is on the line.
      fork
        node_u.recv(got);
        begin
          wt(200);
          wr(`ULAB_ADR_CTL, 32'h40);
        end
      join
      chk(got, b);
      chk(rts, oe_pin(p[0], 1));
      wt(519);
      chk(rts, oe_pin(p[0], 1));
      wt(1730);
      chk(rts, oe_pin(p[0], 0));
      wr(`ULAB_ADR_CTL, 0);
    end
    $display("enable test done");
    complete_run();
  end
endmodule // ulab_usart_ctrl_tb
